// ### design/wave_table_top.sv
// Microstep wave table of the first motor axis: APB registers, table build
// and sine/cosine lookup for both coils.
// Assumes the microstep counter and width select come from logic on i_core_clk.
//
// Behaviour
// RQ1: Each table bit sets the step between neighbouring entries, with its segment width.
// RQ2: Clear bit gives -1,0,+1,+2; set bit gives 0,+1,+2,+3 per width code.
// RQ3: Table holds the first quarter; other quarters are mirrored and negated.
// RQ4: Coil currents at position 0 start from the programmed start values.
// RQ5: Offsets 31..0 sit in word 0 bits 31..0; word 7 holds 255..224.
// RQ6: Reset loads the sine table; word 7 resets to 0x00404222.
// RQ7: Start register bits 31:24 hold the signed coil B phase offset.
// RQ8: Software adapts coil B start value when it changes the phase offset.
// RQ9: Start register bits 23:16 give the current of table entry 256.
// RQ10: Start register bits 7:0 give entry 0 current and reset to zero.
// RQ11: Each entry is the previous one plus its decoded step.
// RQ12: Start register bits 15:8 read zero and ignore writes.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module wave_table_top (
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic [9:0] i_microstep_counter,
   input wire logic [31:0] i_segment_width_select,
   output logic signed [8:0] o_coil_a_current,
   output logic signed [8:0] o_coil_b_current,
   output logic o_table_busy
);

   table_build_if build ();

   logic [31:0] lut_word [wave_table_pkg::WORDS];
   logic [255:0] lut_flat;
   logic [7:0] qtab [wave_table_pkg::QUARTER];
   logic [7:0] coil_b_phase_offset;
   logic [7:0] coil_b_start_value;
   logic [7:0] coil_a_start_value;
   logic build_req;
   logic [31:0] sel_seen;

   // Folds the mirrored quarters onto an index 0..256 of the quarter table.
   function automatic logic [8:0] quarter_index(input logic [9:0] pos);
      if (pos[8]) begin
         return 9'(wave_table_pkg::QUARTER) - {1'b0, pos[7:0]};
      end
      return {1'b0, pos[7:0]};
   endfunction

   function automatic logic signed [8:0] signed_current(input logic neg, input logic [7:0] mag);
      if (neg) begin
         return -$signed({1'b0, mag});
      end
      return $signed({1'b0, mag});
   endfunction

   wave_table_builder builder (
      .i_core_clk (i_core_clk),
      .i_arst_n (i_arst_n),
      .bus (build.builder)
   );

   // Bus decode.
   wire setup = i_psel && !i_penable;
   wire commit = i_psel && i_penable && o_pready;
   wire [7:0] reg_idx = i_paddr[9:2];
   wire aligned = i_paddr[11:10] == 2'b00 && i_paddr[1:0] == 2'b00;
   wire hit_word = aligned && reg_idx >= wave_table_pkg::IDX_WORD0
                   && reg_idx <= wave_table_pkg::IDX_WORD7;
   wire [2:0] word_sel = 3'(reg_idx - wave_table_pkg::IDX_WORD0);
   wire hit_start = aligned && reg_idx == wave_table_pkg::IDX_START;
   wire hit_status = aligned && reg_idx == wave_table_pkg::IDX_STATUS;
   wire mapped = hit_word || hit_start || hit_status;
   wire wr_word = commit && i_pwrite && hit_word;
   wire wr_start = commit && i_pwrite && hit_start;

   // RQ12: middle byte held at zero.
   wire [31:0] start_reg = {coil_b_phase_offset, coil_b_start_value, 8'h00, coil_a_start_value};
   wire [31:0] status_reg = {o_table_busy, 6'h00, o_coil_b_current, 7'h00, o_coil_a_current};
   wire [31:0] read_value = hit_word ? lut_word[word_sel]
                          : hit_start ? start_reg
                          : hit_status ? status_reg
                          : 32'h00000000;
   wire [31:0] start_merged = wave_table_pkg::merge_bytes(start_reg, i_pwdata, i_pstrb);
   wire [31:0] word_merged = wave_table_pkg::merge_bytes(lut_word[word_sel], i_pwdata, i_pstrb);

   // Any change to the bits, entry 0 or segment layout rebuilds the table.
   wire sel_changed = i_segment_width_select != sel_seen;
   wire next_build_req = wr_word || wr_start || sel_changed;
   wire table_ready = !build.busy && !build_req;

   // The answer comes one cycle after setup, so reads are registered.
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_pready <= 1'b0;
         o_prdata <= 32'h00000000;
         o_pslverr <= 1'b0;
      end else begin
         o_pready <= setup;
         o_pslverr <= setup && !mapped;
         if (setup) begin
            o_prdata <= i_pwrite ? 32'h00000000 : read_value;
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         // RQ6: sine table at reset.
         for (int k = 0; k < wave_table_pkg::WORDS; k++) begin
            lut_word[k] <= wave_table_pkg::word_reset(k);
         end
         coil_b_phase_offset <= wave_table_pkg::OFS_RESET;
         coil_b_start_value <= wave_table_pkg::START_B_RESET;
         // RQ10: entry 0 resets to zero.
         coil_a_start_value <= wave_table_pkg::START_A_RESET;
         build_req <= 1'b1;
         sel_seen <= 32'h00000000;
      end else begin
         if (wr_word) begin
            lut_word[word_sel] <= word_merged;
         end
         if (wr_start) begin
            // RQ7: phase offset field.
            coil_b_phase_offset <= start_merged[wave_table_pkg::OFS_LSB +: 8];
            coil_b_start_value <= start_merged[wave_table_pkg::START_B_LSB +: 8];
            coil_a_start_value <= start_merged[wave_table_pkg::START_A_LSB +: 8];
         end
         build_req <= next_build_req;
         sel_seen <= i_segment_width_select;
      end
   end

   // RQ5: offset n is bit n.
   always_comb begin
      lut_flat = '0;
      for (int k = 0; k < wave_table_pkg::WORDS; k++) begin
         lut_flat[32*k +: 32] = lut_word[k];
      end
   end

   assign build.start = build_req;
   assign build.lut_bits = lut_flat;
   assign build.width_select = i_segment_width_select;
   // RQ4: entry 0 seeded from coil A start.
   assign build.start_value = coil_a_start_value;

   // RQ11: quarter table filled by the builder.
   always_ff @(posedge i_core_clk) begin
      if (build.wr_en) begin
         qtab[build.wr_index] <= build.wr_data;
      end
   end

   // RQ7: coil B runs a quarter wave plus the signed offset ahead.
   wire [9:0] pos_b = i_microstep_counter + wave_table_pkg::POS_QUARTER
                      + {{2{coil_b_phase_offset[7]}}, coil_b_phase_offset};
   // RQ3: mirror and negate the quarter.
   wire [8:0] qi_a = quarter_index(i_microstep_counter);
   wire [8:0] qi_b = quarter_index(pos_b);
   // RQ9: entry 256 is the coil B start value.
   wire [7:0] mag_a = qi_a[8] ? coil_b_start_value : qtab[qi_a[7:0]];
   wire [7:0] mag_b = qi_b[8] ? coil_b_start_value : qtab[qi_b[7:0]];
   wire signed [8:0] next_coil_a = signed_current(i_microstep_counter[9], mag_a);
   wire signed [8:0] next_coil_b = signed_current(pos_b[9], mag_b);

   // Coil current outputs hold their last value while the table is being rebuilt.
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_coil_a_current <= 9'sh000;
         o_coil_b_current <= 9'sh000;
         o_table_busy <= 1'b1;
      end else begin
         o_table_busy <= !table_ready;
         if (table_ready) begin
            o_coil_a_current <= next_coil_a;
            o_coil_b_current <= next_coil_b;
         end
      end
   end

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_arst_n);

   a_reset_sine_word: assert property ( // RQ6
      $rose(i_arst_n) |-> lut_word[7] == wave_table_pkg::WORD7_RESET
                          && lut_word[5] == wave_table_pkg::WORD5_RESET)
      else $error("table word not at sine default after reset");

   a_reset_start_a: assert property ( // RQ10
      $rose(i_arst_n) |-> coil_a_start_value == wave_table_pkg::START_A_RESET && build_req)
      else $error("coil A start value not cleared by reset");

   a_bit_order_top: assert property ( // RQ5
      wr_word && word_sel == 3'h7 && i_pstrb == 4'hf |=> lut_flat[255:224] == $past(i_pwdata))
      else $error("word 7 does not hold offsets 255 to 224");

   a_offset_write: assert property ( // RQ7
      wr_start && i_pstrb[3] |=> coil_b_phase_offset == $past(i_pwdata[31:24]) && build.start)
      else $error("phase offset not taken from bits 31 to 24");

   a_unused_zero: assert property ( // RQ12
      setup && hit_start && !i_pwrite |=> o_pready && o_prdata[15:8] == 8'h00)
      else $error("start register middle byte not zero");

   a_entry_zero: assert property ( // RQ4
      $fell(build.busy) && !build_req |-> qtab[0] == coil_a_start_value)
      else $error("entry 0 differs from coil A start value");

   a_quadrant_mirror: assert property ( // RQ3
      table_ready && i_microstep_counter[9:8] == 2'b10 ##0 table_ready[*1]
      |=> o_coil_a_current == -$signed({1'b0, qtab[$past(i_microstep_counter[7:0])]}))
      else $error("third quarter is not the negated first quarter");

   a_entry_256: assert property ( // RQ9
      table_ready && i_microstep_counter == wave_table_pkg::POS_QUARTER
      |=> o_coil_a_current == $signed({1'b0, $past(coil_b_start_value)}))
      else $error("entry 256 is not the coil B start value");

   a_busy_at_reset: assert property ( // RQ6
      $rose(i_arst_n)
      |-> o_table_busy && build.start)
      else $error("no table rebuild pending after reset");

   // Register checks: byte-lane writes of the addressed word, word read-back, and the table rebuild after a write or a select change.
   a_word_full_write: assert property ( // RQ5
      wr_word && i_pstrb == 4'hf
      |=> lut_word[$past(word_sel)] == $past(i_pwdata))
      else $error("table word not written from the bus data");

   a_word_lane_keep: assert property ( // RQ5
      wr_word && !i_pstrb[1]
      |=> lut_word[$past(word_sel)][15:8] == $past(lut_word[word_sel][15:8]))
      else $error("masked byte lane of a table word changed");

   a_read_word: assert property ( // RQ5
      setup && hit_word && !i_pwrite
      |=> o_prdata == $past(lut_word[word_sel]))
      else $error("table word read back wrong");

   a_start_b_write: assert property ( // RQ9
      wr_start && i_pstrb[2]
      |=> coil_b_start_value == $past(i_pwdata[23:16]))
      else $error("coil B start value not taken from bits 23 to 16");

   a_start_a_write: assert property ( // RQ4
      wr_start && i_pstrb[0]
      |=> coil_a_start_value == $past(i_pwdata[7:0]))
      else $error("coil A start value not taken from bits 7 to 0");

   a_write_rebuilds: assert property ( // RQ11
      wr_word || wr_start
      |=> build.start ##1 o_table_busy)
      else $error("register write did not restart the table build");

   a_select_rebuilds: assert property ( // RQ1
      i_segment_width_select != sel_seen
      |=> build.start)
      else $error("segment select change did not restart the table build");

   a_table_busy_out: assert property ( // RQ11
      build.busy
      |=> o_table_busy)
      else $error("table busy output low while the builder runs");

   // Lookup checks rely on the quarter table staying frozen while table_ready is high.
   a_busy_holds_coil: assert property ( // RQ11
      !table_ready
      |=> $stable(o_coil_a_current) && $stable(o_coil_b_current))
      else $error("coil currents moved during a table rebuild");

   a_first_quarter: assert property ( // RQ3
      table_ready && i_microstep_counter[9:8] == 2'b00
      |=> o_coil_a_current == $signed({1'b0, qtab[$past(i_microstep_counter[7:0])]}))
      else $error("first quarter is not the table entry");

   a_second_quarter: assert property ( // RQ3
      table_ready && i_microstep_counter[9:8] == 2'b01 && i_microstep_counter[7:0] != 8'h00
      |=> o_coil_a_current == $signed({1'b0, qtab[8'(wave_table_pkg::QUARTER - $past(i_microstep_counter[7:0]))]}))
      else $error("second quarter is not the mirrored table");

   a_fourth_quarter: assert property ( // RQ3
      table_ready && i_microstep_counter[9:8] == 2'b11 && i_microstep_counter[7:0] != 8'h00
      |=> o_coil_a_current == -$signed({1'b0, qtab[8'(wave_table_pkg::QUARTER - $past(i_microstep_counter[7:0]))]}))
      else $error("fourth quarter is not the mirrored negated table");

   a_coil_b_lead: assert property ( // RQ7
      table_ready && coil_b_phase_offset == 8'h00 && i_microstep_counter == 10'h000
      |=> o_coil_b_current == $signed({1'b0, $past(coil_b_start_value)}))
      else $error("coil B does not lead coil A by a quarter wave");

   a_coil_b_negative: assert property ( // RQ3
      table_ready && coil_b_phase_offset == 8'h00 && i_microstep_counter == 10'h200
      |=> o_coil_b_current == -$signed({1'b0, $past(coil_b_start_value)}))
      else $error("coil B not negated in its fourth quarter");

endmodule
`default_nettype wire

// ### design/wave_table_pkg.sv
// Constants, register map and helper functions of the microstep wave table.
// Assumes a 32-bit APB register bus and a 10-bit microstep position.
package wave_table_pkg;

   localparam int unsigned WORDS = 8;
   localparam int unsigned QUARTER = 256;

   // Register indices; the byte address is four times the index.
   localparam logic [7:0] IDX_WORD0 = 8'h8a;
   localparam logic [7:0] IDX_WORD7 = 8'h91;
   localparam logic [7:0] IDX_START = 8'h92;
   localparam logic [7:0] IDX_STATUS = 8'h94;

   localparam int unsigned OFS_LSB = 24;
   localparam int unsigned START_B_LSB = 16;
   localparam int unsigned START_A_LSB = 0;
   localparam logic [7:0] OFS_RESET = 8'h00;
   localparam logic [7:0] START_B_RESET = 8'hf7;
   localparam logic [7:0] START_A_RESET = 8'h00;

   localparam logic [31:0] WORD0_RESET = 32'h00000000;
   localparam logic [31:0] WORD1_RESET = 32'h00000000;
   localparam logic [31:0] WORD2_RESET = 32'h00000000;
   localparam logic [31:0] WORD3_RESET = 32'h00000000;
   localparam logic [31:0] WORD4_RESET = 32'hfbffffff;
   localparam logic [31:0] WORD5_RESET = 32'hb5bb777d;
   localparam logic [31:0] WORD6_RESET = 32'h49295556;
   localparam logic [31:0] WORD7_RESET = 32'h00404222;

   localparam int unsigned SEL_X1_LSB = 8;
   localparam int unsigned SEL_X2_LSB = 16;
   localparam int unsigned SEL_X3_LSB = 24;

   localparam int unsigned STAT_BUSY_BIT = 31;
   localparam logic [9:0] POS_QUARTER = 10'h100;
   localparam logic [7:0] LAST_ENTRY = 8'hff;

   function automatic logic [31:0] word_reset(input int unsigned k);
      case (k)
         0: return WORD0_RESET;
         1: return WORD1_RESET;
         2: return WORD2_RESET;
         3: return WORD3_RESET;
         4: return WORD4_RESET;
         5: return WORD5_RESET;
         6: return WORD6_RESET;
         default: return WORD7_RESET;
      endcase
   endfunction

   // Width code of the segment that holds quarter-wave entry idx.
   function automatic logic [1:0] segment_code(input logic [31:0] sel, input logic [7:0] idx);
      if (idx < sel[SEL_X1_LSB +: 8]) begin
         return sel[1:0];
      end else if (idx < sel[SEL_X2_LSB +: 8]) begin
         return sel[3:2];
      end else if (idx < sel[SEL_X3_LSB +: 8]) begin
         return sel[5:4];
      end
      return sel[7:6];
   endfunction

   // Two's complement step: width code plus table bit, minus one.
   function automatic logic [7:0] step_of(input logic b, input logic [1:0] code);
      return {6'h00, code} + {7'h00, b} - 8'h01;
   endfunction

   function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wdata,
                                               input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = wdata[8*b +: 8];
         end
      end
      return r;
   endfunction

endpackage

// ### design/table_build_if.sv
// Link between the register owner and the quarter-wave table builder.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface table_build_if;
   logic start;
   logic [255:0] lut_bits;
   logic [31:0] width_select;
   logic [7:0] start_value;
   logic busy;
   logic wr_en;
   logic [7:0] wr_index;
   logic [7:0] wr_data;
   modport builder (input start, lut_bits, width_select, start_value,
                    output busy, wr_en, wr_index, wr_data);
   modport owner (output start, lut_bits, width_select, start_value,
                  input busy, wr_en, wr_index, wr_data);
endinterface
`default_nettype wire

// ### design/wave_table_builder.sv
// Walks the 256 differential bits and emits one quarter-wave entry per cycle.
// Assumes the owner keeps bits and select steady or restarts it on change.
`timescale 1ns/1ps
`default_nettype none
module wave_table_builder (
   input wire logic i_core_clk,
   input wire logic i_arst_n,
   table_build_if.builder bus
);

   logic busy;
   logic [7:0] idx;
   logic [7:0] acc;

   // RQ1: segment width lookup.
   wire [1:0] code = wave_table_pkg::segment_code(bus.width_select, idx);
   wire bit_v = bus.lut_bits[idx];
   // RQ2: increment decode.
   wire [7:0] next_acc = acc + wave_table_pkg::step_of(bit_v, code);
   wire [7:0] exp_step = bit_v ? {6'h00, code} : {6'h00, code} - 8'h01;

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         busy <= 1'b0;
         idx <= 8'h00;
         acc <= 8'h00;
      end else if (bus.start) begin
         // RQ11: accumulate from start value.
         busy <= 1'b1;
         idx <= 8'h00;
         acc <= bus.start_value;
      end else if (busy) begin
         acc <= next_acc;
         idx <= idx + 8'h01;
         busy <= idx != wave_table_pkg::LAST_ENTRY;
      end
   end

   assign bus.busy = busy;
   assign bus.wr_en = busy;
   assign bus.wr_index = idx;
   assign bus.wr_data = acc;

   a_build_first_entry: assert property ( // RQ11
      @(posedge i_core_clk) disable iff (!i_arst_n)
      bus.start |=> bus.wr_en && bus.wr_index == 8'h00 && bus.wr_data == $past(bus.start_value))
      else $error("first entry is not the start value");

   a_step_increment: assert property ( // RQ2
      @(posedge i_core_clk) disable iff (!i_arst_n)
      busy && !bus.start && idx != wave_table_pkg::LAST_ENTRY
      |=> bus.wr_data == 8'($past(acc) + $past(exp_step)) && bus.wr_index == 8'($past(idx) + 8'h01))
      else $error("entry step does not match bit and width code");

   a_segment_edges: assert property ( // RQ1
      @(posedge i_core_clk) disable iff (!i_arst_n)
      busy |-> (idx < bus.width_select[15:8] ? code == bus.width_select[1:0] :
                idx >= bus.width_select[23:16] && idx >= bus.width_select[31:24]
                ? code == bus.width_select[7:6] : 1'b1))
      else $error("wrong segment width code");

endmodule
`default_nettype wire

// ### verification/microstep_wave_table_tb.sv
// Self-checking bench of the microstep wave table: registers over APB and coil lookup.
// Assumes the design answers APB with pready and follows the counter one cycle late.
`timescale 1ns/1ps
`default_nettype none
module microstep_wave_table_tb;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'hf;
   logic [9:0] cnt = 10'h000;
   logic [31:0] sel = 32'hc0804000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic busy;
   logic signed [8:0] coil_a_current;
   logic signed [8:0] coil_b_current;
   int n_fail = 0;
   int tests_run = 0;
   int cycles = 0;
   logic [31:0] words [8];
   logic [31:0] start_reg;
   logic [7:0] tbl [257];
   logic [31:0] rd;
   logic err;
   logic [31:0] d;
   logic [31:0] exp_w;
   logic [31:0] rst_words [8] = '{wave_table_pkg::WORD0_RESET, wave_table_pkg::WORD1_RESET,
      wave_table_pkg::WORD2_RESET, wave_table_pkg::WORD3_RESET, wave_table_pkg::WORD4_RESET,
      wave_table_pkg::WORD5_RESET, wave_table_pkg::WORD6_RESET, 32'h00404222};
   logic [9:0] corners [7] = '{10'h000, 10'h0ff, 10'h100, 10'h1ff, 10'h200, 10'h300, 10'h3ff};

   wave_table_top i_dut (.i_core_clk(clk), .i_arst_n(arst_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_microstep_counter(cnt),
      .i_segment_width_select(sel), .o_coil_a_current(coil_a_current), .o_coil_b_current(coil_b_current),
      .o_table_busy(busy));

   initial begin
      forever #12.5 clk = ~clk;
   end

   task automatic tally_and_finish();
      $display("Counts: %0d comparisons, %0d mismatches", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // A hang anywhere ends the run as a failure.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_fail = n_fail + 1;
         $display("ERROR timeout expected finish seen hang");
         tally_and_finish();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data, input logic [3:0] strb);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      pstrb <= strb;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [11:0] addr_of(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction

   // Width code of the segment holding entry i, from the select fields.
   function automatic logic [1:0] code_at(input logic [7:0] i);
      if (i < sel[15:8]) return sel[1:0];
      if (i < sel[23:16]) return sel[3:2];
      if (i < sel[31:24]) return sel[5:4];
      return sel[7:6];
   endfunction

   task automatic build();
      logic [1:0] c;
      tbl[0] = start_reg[7:0];
      for (int i = 0; i < 255; i++) begin
         c = code_at(8'(i));
         tbl[i+1] = tbl[i] + {6'h00, c} + {7'h00, words[i/32][i%32]} - 8'h01;
      end
      tbl[256] = start_reg[23:16];
   endtask

   function automatic logic [31:0] ref_cur(input logic [9:0] p);
      logic [8:0] v;
      v = {1'b0, p[8] ? tbl[256 - int'(p[7:0])] : tbl[p[7:0]]};
      if (p[9]) v = -v;
      return {{23{v[8]}}, v};
   endfunction

   task automatic probe(input logic [9:0] p);
      logic [9:0] pb;
      pb = p + 10'h100 + {{2{start_reg[31]}}, start_reg[31:24]};
      @(posedge clk);
      cnt <= p;
      @(posedge clk);
      @(negedge clk);
      chk("coil_a_current", ref_cur(p), {{23{coil_a_current[8]}}, coil_a_current});
      chk("coil_b_current", ref_cur(pb), {{23{coil_b_current[8]}}, coil_b_current});
   endtask

   task automatic settle_and_probe(input string name);
      int n;
      n = 0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      while (busy !== 1'b0 && n < 400) begin
         n++;
         @(negedge clk);
      end
      chk("table_busy", 32'h0, {31'h0, busy});
      build();
      foreach (corners[j]) probe(corners[j]);
      for (int j = 0; j < 40; j++) probe(10'($urandom()));
      $display("Test %s finished", name);
   endtask

   initial begin
      void'($urandom(32'ha93d));
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      for (int k = 0; k < 8; k++) begin
         apb(1'b0, addr_of(8'(wave_table_pkg::IDX_WORD0 + k)), 32'h0, 4'hf);
         chk("table_word", rst_words[k], rd);
         words[k] = rst_words[k];
      end
      apb(1'b0, addr_of(wave_table_pkg::IDX_START), 32'h0, 4'hf);
      start_reg = {wave_table_pkg::OFS_RESET, wave_table_pkg::START_B_RESET, 8'h00, 8'h00};
      chk("start_reset", start_reg, rd);
      settle_and_probe("reset_table");
      apb(1'b0, 12'h000, 32'h0, 4'hf);
      chk("unmapped_err", 32'h1, {31'h0, err});
      chk("unmapped_data", 32'h0, rd);
      apb(1'b1, addr_of(wave_table_pkg::IDX_WORD7) | 12'h001, 32'hffffffff, 4'hf);
      chk("unaligned_err", 32'h1, {31'h0, err});
      d = $urandom();
      apb(1'b1, addr_of(wave_table_pkg::IDX_WORD0 + 8'h03), d, 4'h5);
      exp_w = words[3];
      exp_w[7:0] = d[7:0];
      exp_w[23:16] = d[23:16];
      words[3] = exp_w;
      apb(1'b0, addr_of(wave_table_pkg::IDX_WORD0 + 8'h03), 32'h0, 4'hf);
      chk("lane_write", exp_w, rd);
      apb(1'b0, addr_of(wave_table_pkg::IDX_WORD7), 32'h0, 4'hf);
      chk("word7_kept", 32'h00404222, rd);
      settle_and_probe("register_access");
      for (int r = 0; r < 3; r++) begin
         @(posedge clk);
         sel <= (r == 2) ? 32'hff_ff_ff_00 | $urandom_range(255) : $urandom();
         for (int k = 0; k < 8; k++) begin
            words[k] = $urandom();
            apb(1'b1, addr_of(8'(wave_table_pkg::IDX_WORD0 + k)), words[k], 4'hf);
         end
         d = $urandom();
         d[31:24] = (r == 0) ? 8'h7f : (r == 1) ? 8'h81 : 8'($urandom_range(254) - 127);
         if (r == 0) begin
            // Coil B start carries on from the last quarter entry, so the wave has no step there.
            start_reg = d;
            build();
            d[23:16] = tbl[255] + {6'h00, code_at(8'hff)} + {7'h00, words[7][31]} - 8'h01;
         end
         apb(1'b1, addr_of(wave_table_pkg::IDX_START), d | 32'h0000ff00, 4'hf);
         start_reg = d & 32'hffff00ff;
         apb(1'b0, addr_of(wave_table_pkg::IDX_START), 32'h0, 4'hf);
         chk("start_read", start_reg, rd);
         settle_and_probe("random_table");
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
